// ==== atms_pkg.sv ====
// constants and carrier types for the mono-mode / slip-flag transmitter block
`default_nettype none
package atms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int SMP_W  = 24;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [7:0]        IDX_CTRL = 8'h01;
  localparam logic [7:0]        IDX_STAT = 8'h04;
  localparam logic [7:0]        IDX_IRQC = 8'h05;
  localparam logic [ADDR_W-1:0] ADR_CTRL = {IDX_CTRL[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADR_STAT = {IDX_STAT[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADR_IRQC = {IDX_IRQC[5:0], 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTRL_MONO = 0;
  localparam int CTRL_ADAT = 1;
  localparam int CTRL_CSRC = 2;
  localparam int STAT_SLIP = 0;
  localparam int IRQC_MASK = 0;
  localparam int IRQC_SEL  = 4;

  localparam logic [7:0] CTRL_WMASK = 8'h07;
  localparam logic [7:0] IRQC_WMASK = 8'h11;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] IRQC_RST   = 8'h01;
  localparam logic [7:0] STAT_RST   = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_CTRL = 2'h1;
  localparam logic [1:0] SEL_STAT = 2'h2;
  localparam logic [1:0] SEL_IRQC = 2'h3;

  // slot fill counts of the frame holding stage
  localparam logic [1:0] CNT_EMPTY = 2'h0;
  localparam logic [1:0] CNT_HALF  = 2'h1;
  localparam logic [1:0] CNT_FULL  = 2'h2;

  // pin positions in the synchroniser vector
  localparam int PIN_HW   = 0;
  localparam int PIN_MONO = 1;
  localparam int PIN_MSRC = 2;
  localparam int PIN_BLK  = 3;
  localparam int PIN_N    = 4;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [SMP_W-1:0] sub_a;
    logic [SMP_W-1:0] sub_b;
    logic             cs_a;
    logic             cs_b;
  } atms_frame_t;

  typedef struct packed {
    logic [SMP_W-1:0] left;
    logic [SMP_W-1:0] right;
    logic             cs_a;
    logic             cs_b;
  } atms_pair_t;

  typedef struct packed {
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } atms_axi_t;

  typedef struct packed {
    atms_axi_t   axi;
    logic [7:0]  ctrl;
    logic [7:0]  irqc;
    logic [7:0]  stat;
    logic        irq_n;
    atms_frame_t slot;
    logic [1:0]  cnt;
    atms_frame_t frame;
    logic        frame_vld;
    logic        blk_d;
  } atms_state_t;

endpackage
`default_nettype wire

// ==== atms_rx_model.sv ====
// far-side frame receiver model: pulls frames and issues internal block starts
`timescale 1ns/1ps
`default_nettype none
module atms_rx_model (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  // frame stream
  output var  logic                  frame_req,
  output var  logic                  blk_start_int,
  input  wire logic                  frm_valid,
  input  wire atms_pkg::atms_frame_t frm_data
);
  import atms_pkg::*;

  atms_frame_t got;
  int          late_cnt;

  initial begin
    frame_req     = 1'b0;
    blk_start_int = 1'b0;
    late_cnt      = 0;
  end

  // idle cycles first model a slow encoder
  task automatic pull(input int idle);
    repeat (idle) @(posedge sys_clk);
    @(posedge sys_clk);
    frame_req <= 1'b1;
    @(posedge sys_clk);
    frame_req <= 1'b0;
    @(negedge sys_clk);
    if (frm_valid !== 1'b1) late_cnt++;
    got = frm_data;
    @(negedge sys_clk);
    // strobe must not linger past one cycle
    if (frm_valid !== 1'b0) late_cnt++;
  endtask

  task automatic blk_pulse();
    @(posedge sys_clk);
    blk_start_int <= 1'b1;
    @(posedge sys_clk);
    blk_start_int <= 1'b0;
  endtask
endmodule // atms_rx_model
`default_nettype wire

// ==== atms_sync.sv ====
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module atms_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  // pins and synchronised copies
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] pin_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } atms_sync_state_t;

  atms_sync_state_t sync_ff;
  atms_sync_state_t nxt_sync;

  always_comb begin
    nxt_sync        = sync_ff;
    nxt_sync.meta   = pin_in;
    nxt_sync.stable = sync_ff.meta;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign pin_sync = sync_ff.stable;

endmodule // atms_sync
`default_nettype wire

// ==== atms_top.sv ====
// mono-mode sample pairing, slip / block-start flag and interrupt, axi4-lite registers
//
// Function
// - select bit picks slip or block-start meaning
// - flag active high, sticky, cleared by status read
// - slip mode: dropped or repeated sample sets flag
// - block-start mode: internal or pin start sets flag
// - mono: two consecutive selected samples fill A,B
// - hardware mode: pin selects stereo or mono
// - source 0 left/A, source 1 right/B
// - software mode: control bits set mono operation
// - unmasked event drives interrupt low until read
// - mask bit keeps event off interrupt output
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module atms_top (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         nrst,
  // axi4-lite slave
  input  wire logic [atms_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output var  logic                         s_axi_awready,
  input  wire logic [atms_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output var  logic                         s_axi_wready,
  output var  logic [1:0]                   s_axi_bresp,
  output var  logic                         s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [atms_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output var  logic                         s_axi_arready,
  output var  logic [atms_pkg::DATA_W-1:0]  s_axi_rdata,
  output var  logic [1:0]                   s_axi_rresp,
  output var  logic                         s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // hardware-mode pins and block start pin (asynchronous)
  input  wire logic                         hw_mode_pin,
  input  wire logic                         mono_select_pin,
  input  wire logic                         single_channel_audio_source,
  input  wire logic                         block_start_io,
  // audio sample pairs from the serial port, same clock
  input  wire logic                         smp_valid,
  input  wire atms_pkg::atms_pair_t         smp_pair,
  // frame timing from the line encoder, same clock
  input  wire logic                         frame_req,
  input  wire logic                         blk_start_int,
  // frame handed to the line encoder
  output var  logic                         frm_valid,
  output var  atms_pkg::atms_frame_t        frm_data,
  // interrupt
  output var  logic                         irq_n
);
  import atms_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] addr);
    logic [1:0] sel;
    sel = SEL_NONE;
    if (addr == ADR_CTRL) begin
      sel = SEL_CTRL;
    end else if (addr == ADR_STAT) begin
      sel = SEL_STAT;
    end else if (addr == ADR_IRQC) begin
      sel = SEL_IRQC;
    end
    return sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_s;

  assign pin_raw[PIN_HW]   = hw_mode_pin;
  assign pin_raw[PIN_MONO] = mono_select_pin;
  assign pin_raw[PIN_MSRC] = single_channel_audio_source;
  assign pin_raw[PIN_BLK]  = block_start_io;

  atms_sync #(
    .W (PIN_N)
  ) u_sync (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .pin_in   (pin_raw),
    .pin_sync (pin_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  atms_state_t q_ff;
  atms_state_t nxt_q;

  logic             mono_eff;
  logic             adat_eff;
  logic             csrc_eff;
  logic             slip_evt;
  logic             blk_evt;
  logic             set_evt;
  logic             rd_clear;
  logic [SMP_W-1:0] mono_smp;
  logic             mono_cs;

  // hardware pins win when strapped to hardware mode
  always_comb begin
    mono_eff = pin_s[PIN_HW] ? pin_s[PIN_MONO] : q_ff.ctrl[CTRL_MONO];
    adat_eff = pin_s[PIN_HW] ? pin_s[PIN_MSRC] : q_ff.ctrl[CTRL_ADAT];
    csrc_eff = pin_s[PIN_HW] ? pin_s[PIN_MSRC] : q_ff.ctrl[CTRL_CSRC];
    mono_smp = adat_eff ? smp_pair.right : smp_pair.left;
    mono_cs  = csrc_eff ? smp_pair.cs_b : smp_pair.cs_a;
  end

  always_comb begin
    nxt_q    = q_ff;
    slip_evt = 1'b0;
    rd_clear = 1'b0;

    //////////////////////////////////////////////////////////////////////////
    // write channel: address and data in either order
    if (s_axi_awvalid && q_ff.axi.awready) begin
      nxt_q.axi.aw_got = 1'b1;
      nxt_q.axi.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q_ff.axi.wready) begin
      nxt_q.axi.w_got = 1'b1;
      nxt_q.axi.wdata = s_axi_wdata;
      nxt_q.axi.wstrb = s_axi_wstrb;
    end
    if (q_ff.axi.bvalid && s_axi_bready) begin
      nxt_q.axi.bvalid = 1'b0;
    end
    if (q_ff.axi.aw_got && q_ff.axi.w_got && !q_ff.axi.bvalid) begin
      nxt_q.axi.aw_got = 1'b0;
      nxt_q.axi.w_got  = 1'b0;
      nxt_q.axi.bvalid = 1'b1;
      nxt_q.axi.bresp  = RESP_OKAY;
      unique case (reg_sel(q_ff.axi.awaddr))
        SEL_CTRL: begin
          if (q_ff.axi.wstrb[0]) begin
            nxt_q.ctrl = q_ff.axi.wdata[7:0] & CTRL_WMASK;
          end
        end
        SEL_IRQC: begin
          if (q_ff.axi.wstrb[0]) begin
            nxt_q.irqc = q_ff.axi.wdata[7:0] & IRQC_WMASK;
          end
        end
        // status is read-only; only a read clears it
        SEL_STAT: begin
          nxt_q.axi.bresp = RESP_OKAY;
        end
        SEL_NONE: begin
          nxt_q.axi.bresp = RESP_SLVERR;
        end
      endcase
    end
    nxt_q.axi.awready = !nxt_q.axi.aw_got && !nxt_q.axi.bvalid;
    nxt_q.axi.wready  = !nxt_q.axi.w_got && !nxt_q.axi.bvalid;

    //////////////////////////////////////////////////////////////////////////
    // read channel
    if (s_axi_arvalid && q_ff.axi.arready) begin
      nxt_q.axi.rvalid = 1'b1;
      nxt_q.axi.rresp  = RESP_OKAY;
      nxt_q.axi.rdata  = '0;
      unique case (reg_sel(s_axi_araddr))
        SEL_CTRL: nxt_q.axi.rdata[7:0] = q_ff.ctrl;
        SEL_IRQC: nxt_q.axi.rdata[7:0] = q_ff.irqc;
        SEL_STAT: begin
          nxt_q.axi.rdata[7:0] = q_ff.stat;
          rd_clear             = 1'b1;
        end
        SEL_NONE: nxt_q.axi.rresp = RESP_SLVERR;
      endcase
    end else if (q_ff.axi.rvalid && s_axi_rready) begin
      nxt_q.axi.rvalid = 1'b0;
    end
    nxt_q.axi.arready = !nxt_q.axi.rvalid;

    //////////////////////////////////////////////////////////////////////////
    // frame holding stage; a frame request with no fresh data repeats
    nxt_q.frame_vld = frame_req;
    if (frame_req) begin
      if (q_ff.cnt == CNT_FULL) begin
        nxt_q.frame = q_ff.slot;
        nxt_q.cnt   = CNT_EMPTY;
      end else begin
        slip_evt = 1'b1;
      end
    end
    // new data while the stage is still full is dropped
    if (smp_valid) begin
      if (!mono_eff) begin
        if (nxt_q.cnt == CNT_FULL) begin
          slip_evt = 1'b1;
        end else begin
          nxt_q.slot.sub_a = smp_pair.left;
          nxt_q.slot.sub_b = smp_pair.right;
          nxt_q.slot.cs_a  = smp_pair.cs_a;
          nxt_q.slot.cs_b  = smp_pair.cs_b;
          nxt_q.cnt        = CNT_FULL;
        end
      end else begin
        // mono: consecutive samples of one channel go to A then B
        unique case (nxt_q.cnt)
          CNT_EMPTY: begin
            nxt_q.slot.sub_a = mono_smp;
            nxt_q.slot.cs_a  = mono_cs;
            nxt_q.cnt        = CNT_HALF;
          end
          CNT_HALF: begin
            nxt_q.slot.sub_b = mono_smp;
            nxt_q.slot.cs_b  = mono_cs;
            nxt_q.cnt        = CNT_FULL;
          end
          default: slip_evt = 1'b1;
        endcase
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // flag and interrupt; a set in the clearing cycle wins
    nxt_q.blk_d = pin_s[PIN_BLK];
    blk_evt     = blk_start_int || (pin_s[PIN_BLK] && !q_ff.blk_d);
    set_evt     = q_ff.irqc[IRQC_SEL] ? blk_evt : slip_evt;
    if (set_evt) begin
      nxt_q.stat[STAT_SLIP] = 1'b1;
    end else if (rd_clear) begin
      nxt_q.stat[STAT_SLIP] = 1'b0;
    end
    nxt_q.irq_n = !(nxt_q.stat[STAT_SLIP] && !nxt_q.irqc[IRQC_MASK]);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q_ff             <= '0;
      q_ff.ctrl        <= CTRL_RST;
      q_ff.irqc        <= IRQC_RST;
      q_ff.stat        <= STAT_RST;
      q_ff.irq_n       <= 1'b1;
      q_ff.axi.awready <= 1'b1;
      q_ff.axi.wready  <= 1'b1;
      q_ff.axi.arready <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from q_ff

  assign s_axi_awready = q_ff.axi.awready;
  assign s_axi_wready  = q_ff.axi.wready;
  assign s_axi_bvalid  = q_ff.axi.bvalid;
  assign s_axi_bresp   = q_ff.axi.bresp;
  assign s_axi_arready = q_ff.axi.arready;
  assign s_axi_rvalid  = q_ff.axi.rvalid;
  assign s_axi_rdata   = q_ff.axi.rdata;
  assign s_axi_rresp   = q_ff.axi.rresp;
  assign frm_valid     = q_ff.frame_vld;
  assign frm_data      = q_ff.frame;
  assign irq_n         = q_ff.irq_n;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  a_sel_slip_only: assert property (@(posedge sys_clk) disable iff (!nrst)
    (q_ff.irqc[IRQC_SEL] && !blk_evt && !q_ff.stat[STAT_SLIP])
      |=> !q_ff.stat[STAT_SLIP])
    else $error("slip set flag in block-start mode");

  a_flag_holds: assert property (@(posedge sys_clk) disable iff (!nrst)
    (q_ff.stat[STAT_SLIP] && !rd_clear) |=> q_ff.stat[STAT_SLIP])
    else $error("flag dropped without a status read");

  a_read_clears: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rd_clear && !set_evt) |=> (!q_ff.stat[STAT_SLIP] && s_axi_rvalid))
    else $error("status read did not clear flag");

  a_slip_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
    (slip_evt && !q_ff.irqc[IRQC_SEL]) |=> q_ff.stat[STAT_SLIP])
    else $error("slip did not set flag");

  a_blk_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
    (blk_evt && q_ff.irqc[IRQC_SEL]) |=> q_ff.stat[STAT_SLIP])
    else $error("block start did not set flag");

  a_mono_fill: assert property (@(posedge sys_clk) disable iff (!nrst)
    (mono_eff && smp_valid && !frame_req && q_ff.cnt == CNT_EMPTY)
      |=> (q_ff.cnt == CNT_HALF && q_ff.slot.sub_a == $past(mono_smp)))
    else $error("mono sample not placed in subframe A");

  a_hw_mode_sel: assert property (@(posedge sys_clk) disable iff (!nrst)
    (pin_s[PIN_HW] && pin_s[PIN_MONO] && smp_valid && !frame_req
      && q_ff.cnt == CNT_EMPTY)
      |=> (q_ff.cnt == CNT_HALF && q_ff.slot.sub_a == ($past(pin_s[PIN_MSRC]) ?
           $past(smp_pair.right) : $past(smp_pair.left))))
    else $error("hardware pins not steering mono mode");

  a_sw_mode_sel: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!pin_s[PIN_HW] && q_ff.ctrl[CTRL_MONO] && smp_valid && !frame_req
      && q_ff.cnt == CNT_EMPTY)
      |=> (q_ff.cnt == CNT_HALF && q_ff.slot.cs_a == ($past(q_ff.ctrl[CTRL_CSRC]) ?
           $past(smp_pair.cs_b) : $past(smp_pair.cs_a))))
    else $error("control bits not steering mono mode");

  // mask taken from the next value: a mask write in the event cycle counts
  a_irq_low: assert property (@(posedge sys_clk) disable iff (!nrst)
    (set_evt && !nxt_q.irqc[IRQC_MASK]) |=> (!irq_n && q_ff.stat[STAT_SLIP]))
    else $error("unmasked event did not pull interrupt low");

  a_mask_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
    (q_ff.irqc[IRQC_MASK] || !q_ff.stat[STAT_SLIP]) |-> irq_n)
    else $error("interrupt low while masked or clear");

endmodule // atms_top
`default_nettype wire

// ==== atms_top_tb.sv ====
// self-checking bench: registers, mono pairing, slip/block-start flag, interrupt
`timescale 1ns/1ps
`default_nettype none
module atms_top_tb;
  import atms_pkg::*;

  logic        sys_clk, nrst;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        hw_pin, mono_pin, src_pin, blk_pin, smp_valid;
  logic        frame_req, blk_int, frm_valid, irq_n;
  atms_pair_t  smp_pair;
  atms_frame_t frm_data;
  int          err_total, samples_checked;

  atms_top DUT (
    .sys_clk, .nrst,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hw_mode_pin(hw_pin), .mono_select_pin(mono_pin),
    .single_channel_audio_source(src_pin), .block_start_io(blk_pin),
    .smp_valid, .smp_pair, .frame_req, .blk_start_int(blk_int),
    .frm_valid, .frm_data, .irq_n
  );

  atms_rx_model RX (
    .sys_clk, .nrst, .frame_req, .blk_start_int(blk_int),
    .frm_valid, .frm_data
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // handshakes judged at the falling edge, where everything has settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hs, w_hs, b_hs;
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge sys_clk);
      aw_hs = awvalid && awready;
      w_hs  = wvalid && wready;
      b_hs  = bvalid;
      resp  = bresp;
      @(posedge sys_clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end while (b_hs !== 1'b1);
    bready <= 1'b0;
    check(resp, er);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar_hs, r_hs;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge sys_clk);
      ar_hs = arvalid && arready;
      r_hs  = rvalid;
      rd    = rdata;
      resp  = rresp;
      @(posedge sys_clk);
      if (ar_hs) arvalid <= 1'b0;
    end while (r_hs !== 1'b1);
    rready <= 1'b0;
    check(rd, e);
    check(resp, er);
  endtask

  task automatic send(input logic [7:0] k, input logic ca, input logic cb);
    @(posedge sys_clk);
    smp_valid <= 1'b1;
    smp_pair  <= '{left: {16'ha000, k}, right: {16'hb000, k}, cs_a: ca, cs_b: cb};
    @(posedge sys_clk);
    smp_valid <= 1'b0;
  endtask

  task automatic frame_chk(input logic [23:0] a, input logic [23:0] b,
                           input logic ca, input logic cb);
    RX.pull(0);
    check(RX.got, {a, b, ca, cb});
  endtask

  task automatic irq_chk(input logic e);
    @(negedge sys_clk);
    check(irq_n, e);
  endtask

  task automatic pins(input logic h, input logic m, input logic s);
    @(posedge sys_clk);
    hw_pin   <= h;
    mono_pin <= m;
    src_pin  <= s;
    // two synchroniser flops plus margin
    repeat (4) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready, hw_pin, mono_pin, src_pin, blk_pin, smp_valid} = '0;
    smp_pair        = '0;
    wstrb           = 4'hf;
    err_total       = 0;
    samples_checked = 0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    rd_chk(ADR_CTRL, 32'h0, RESP_OKAY);
    rd_chk(ADR_IRQC, 32'h1, RESP_OKAY);
    rd_chk(ADR_STAT, 32'h0, RESP_OKAY);
    rd_chk(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h24, 32'hff, RESP_SLVERR);
    irq_chk(1'b1);
    // second pair meets a full stage and is dropped
    send(8'h01, 1'b1, 1'b0);
    send(8'h02, 1'b0, 1'b1);
    frame_chk(24'ha00001, 24'hb00001, 1'b1, 1'b0);
    irq_chk(1'b1);
    rd_chk(ADR_STAT, 32'h1, RESP_OKAY);
    rd_chk(ADR_STAT, 32'h0, RESP_OKAY);
    for (logic [7:0] m = 8'h01; m < 8'h08; m += 8'h02) begin
      wr(ADR_CTRL, {24'h0, m}, RESP_OKAY);
      send(m | 8'h10, 1'b1, 1'b0);
      send(m | 8'h20, 1'b0, 1'b1);
      frame_chk({m[1] ? 16'hb000 : 16'ha000, m | 8'h10},
                {m[1] ? 16'hb000 : 16'ha000, m | 8'h20}, !m[2], m[2]);
    end
    // pins override the mono-right setting still held in software
    for (int s = 0; s < 2; s++) begin
      pins(1'b1, 1'b1, s[0]);
      send(8'h31, 1'b1, 1'b0);
      send(8'h32, 1'b0, 1'b1);
      frame_chk({s[0] ? 16'hb000 : 16'ha000, 8'h31},
                {s[0] ? 16'hb000 : 16'ha000, 8'h32}, !s[0], s[0]);
    end
    pins(1'b1, 1'b0, 1'b0);
    send(8'h41, 1'b1, 1'b0);
    frame_chk(24'ha00041, 24'hb00041, 1'b1, 1'b0);
    pins(1'b0, 1'b0, 1'b0);
    wr(ADR_CTRL, 32'h0, RESP_OKAY);
    wr(ADR_IRQC, 32'h0, RESP_OKAY);
    RX.pull(3);
    // no fresh data: the last stereo frame goes out again
    check(RX.got, {24'ha00041, 24'hb00041, 1'b1, 1'b0});
    irq_chk(1'b0);
    rd_chk(ADR_STAT, 32'h1, RESP_OKAY);
    irq_chk(1'b1);
    RX.blk_pulse();
    rd_chk(ADR_STAT, 32'h0, RESP_OKAY);
    wr(ADR_IRQC, 32'h10, RESP_OKAY);
    rd_chk(ADR_IRQC, 32'h10, RESP_OKAY);
    RX.pull(0);
    rd_chk(ADR_STAT, 32'h0, RESP_OKAY);
    RX.blk_pulse();
    irq_chk(1'b0);
    rd_chk(ADR_STAT, 32'h1, RESP_OKAY);
    @(posedge sys_clk);
    blk_pin <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rd_chk(ADR_STAT, 32'h1, RESP_OKAY);
    blk_pin <= 1'b0;
    wr(ADR_IRQC, 32'h11, RESP_OKAY);
    RX.blk_pulse();
    irq_chk(1'b1);
    rd_chk(ADR_STAT, 32'h1, RESP_OKAY);
    wr(ADR_IRQC, 32'h10, RESP_OKAY);
    RX.blk_pulse();
    irq_chk(1'b0);
    // mid-run reset drops a pending flag and its interrupt
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    irq_chk(1'b1);
    @(posedge sys_clk);
    nrst <= 1'b1;
    rd_chk(ADR_IRQC, 32'h1, RESP_OKAY);
    rd_chk(ADR_STAT, 32'h0, RESP_OKAY);
    check(RX.late_cnt, 64'h0);
    complete_run();
  end

  // full sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    complete_run();
  end
endmodule // atms_top_tb
`default_nettype wire
